// >>> verilog/tsf_flags.sv
// Timer status flags: update, trigger, channel and over-capture
//
// Added by the designer: the strobed register port and the register offsets.
`default_nettype none
`timescale 1ns/1ps

// Function
// - The channel 1 over-capture flag is only set while channel 1 captures inputs.
// - A capture into register 1 while the channel 1 event flag is set sets over-capture.
// - Software writing zero to the over-capture bit clears it until the next over-capture.
// - Channel 2 has its own over-capture flag at bit 10, working as channel 1's.
// - The trigger flag at bit 6 is set by each trigger event and held until cleared.
// - A trigger event is the valid edge of the trigger input, or either edge in gated mode.
// - In output mode a compare match sets the channel 1 flag at bit 1, not when centre-aligned.
// - In input mode a capture into register 1 sets the channel 1 event flag.
// - In input mode the channel 1 flag clears by software or by reading capture register 1.
// - Channel 2 has an event flag at bit 2, set and cleared like channel 1's.
// - The update flag at bit 0 is set by each update event but a reinit while the request source is set, and held until cleared.
// - With updates enabled, a repetition counter over- or underflow sets the update flag.
// - With update disable and request source both zero, generate or reinit sets the flag.
// - With both zero, a counter reinit caused by a trigger event sets the update flag.
// - The trigger interrupt is raised only while the trigger flag and its enable are set.
// - Writing one to the trigger generate bit makes a trigger event.
module tsf_flags
   import tsf_pkg::*;
#(
   parameter int ADDR_W = TSF_ADDR_W,  // Register address width
   parameter int DATA_W = TSF_DATA_W,  // Register data width
   parameter int NCHAN  = TSF_NCHAN    // Compare/capture channels
) (
   input  wire logic              SYS_CLK,        // Kernel clock, 125 MHz
   input  wire logic              RESET,          // Async reset, high
   input  wire logic              CLK_EN,         // Freezes all state when low
   // Register port
   input  wire logic [ADDR_W-1:0] REG_ADDR,       // Byte address
   input  wire logic [DATA_W-1:0] REG_WDATA,      // Write data
   input  wire logic              REG_WR,         // Write strobe
   input  wire logic              REG_RD,         // Read strobe
   output logic      [DATA_W-1:0] REG_RDATA,      // Read data, next cycle
   // Counter side events
   input  wire logic              REP_OVF_UNF,    // Repetition counter wrap
   input  wire logic              SW_REINIT,      // Software counter reinit
   input  wire logic              TRIGGER_INPUT,  // Selected trigger input
   input  wire logic [NCHAN-1:0]  CH_MATCH,       // Counter equals compare
   input  wire logic [NCHAN-1:0]  CH_CAPTURE,     // Capture event taken
   input  wire logic [NCHAN-1:0]  CH_CAP_READ,    // Capture register read
   // Event and interrupt outputs
   output logic                   UPDATE_EVT,     // Update event pulse
   output logic                   COUNTER_REINIT, // Counter reinit pulse
   output logic                   TRIGGER_EVT,    // Trigger event pulse
   output logic                   IRQ             // Interrupt, level
);

   // ==================================================
   // Address decode

   // Whole-word match of a register offset
   function automatic logic addr_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [7:0]        ofs
   );
      addr_hit = (addr == ADDR_W'(ofs));
   endfunction : addr_hit

   logic wr_status;
   logic wr_mask;
   logic wr_ctrl;
   logic wr_evgen;
   logic rd_status;
   logic rd_mask;
   logic rd_ctrl;

   // Write and read selects per register
   assign wr_status = REG_WR & addr_hit(REG_ADDR, OFS_STATUS);
   assign wr_mask   = REG_WR & addr_hit(REG_ADDR, OFS_MASK);
   assign wr_ctrl   = REG_WR & addr_hit(REG_ADDR, OFS_CTRL);
   assign wr_evgen  = REG_WR & addr_hit(REG_ADDR, OFS_EVGEN);
   assign rd_status = addr_hit(REG_ADDR, OFS_STATUS);
   assign rd_mask   = addr_hit(REG_ADDR, OFS_MASK);
   assign rd_ctrl   = addr_hit(REG_ADDR, OFS_CTRL);

   // ==================================================
   // Control and mask registers

   logic [15:0] ctrl_reg;
   logic [15:0] mask_reg;
   logic [15:0] ctrl_next;
   logic [15:0] mask_next;

   // Only defined bits are kept, the rest stay zero
   assign ctrl_next = wr_ctrl ? (REG_WDATA[15:0] & CTRL_MASK) : ctrl_reg;
   assign mask_next = wr_mask ? (REG_WDATA[15:0] & FLAG_MASK) : mask_reg;

   // Software settings
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         ctrl_reg <= CTRL_RST;
         mask_reg <= MASK_RST;
      end else if (CLK_EN) begin
         ctrl_reg <= ctrl_next;
         mask_reg <= mask_next;
      end
   end

   // ==================================================
   // Control fields

   logic             update_disable;
   logic             update_request_source;
   logic [2:0]       slave_mode;
   logic             trig_fall_sel;
   logic [NCHAN-1:0] chan_input_mode;
   logic             center_aligned;

   assign update_disable        = ctrl_reg[CTL_UPDATE_DISABLE];
   assign update_request_source = ctrl_reg[CTL_URS];
   assign slave_mode            = ctrl_reg[CTL_SLV_LO +: 3];
   assign trig_fall_sel         = ctrl_reg[CTL_POL];
   assign chan_input_mode       = ctrl_reg[CTL_CH_IN +: NCHAN];
   assign center_aligned        = ctrl_reg[CTL_CENTER];

   // ==================================================
   // Software event generation

   logic update_generate;
   logic trigger_generate;

   // One-cycle pulses; the register itself holds nothing
   assign update_generate  = wr_evgen & REG_WDATA[EVG_UG];
   assign trigger_generate = wr_evgen & REG_WDATA[EVG_TG];

   // ==================================================
   // Trigger events

   logic hw_trig;
   logic trig_evt;
   logic trig_reinit;

   tsf_trig_edge u_trig_edge (
      .clk        (SYS_CLK),
      .rst        (RESET),
      .ce         (CLK_EN),
      .trig_in    (TRIGGER_INPUT),
      .slave_mode (slave_mode),
      .fall_sel   (trig_fall_sel),
      .trig_evt   (hw_trig)
   );

   // Input edge or software generate
   assign trig_evt = hw_trig | trigger_generate;
   // Reset mode restarts the counter on each trigger
   assign trig_reinit = trig_evt & (slave_mode == SLV_RESET);

   // ==================================================
   // Update events

   logic upd_any;
   logic upd_evt;
   logic upd_flag_set;
   logic reinit_src;

   // Sources that reinitialise the counter
   assign reinit_src = update_generate | SW_REINIT | trig_reinit;
   // Generate still reinits the counter while updates are disabled
   assign upd_any = REP_OVF_UNF | reinit_src;
   assign upd_evt = ~update_disable & upd_any;
   // Request source set limits the flag to counter wraps only
   assign upd_flag_set = ~update_disable & (REP_OVF_UNF
                       | (~update_request_source & reinit_src));

   // ==================================================
   // Status flag clears

   logic [15:0] clr_bits;

   // A zero written to a flag bit clears it; ones are ignored
   assign clr_bits = wr_status ? (FLAG_MASK & ~REG_WDATA[15:0]) : 16'h0000;

   // ==================================================
   // Update and trigger flags

   logic upd_flag_reg;
   logic trg_flag_reg;
   logic upd_flag_next;
   logic trg_flag_next;

   // Set beats a clear written in the same cycle
   assign upd_flag_next = upd_flag_set | (upd_flag_reg & ~clr_bits[BIT_UPD]);
   assign trg_flag_next = trig_evt | (trg_flag_reg & ~clr_bits[BIT_TRG]);

   // Sticky flags
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         upd_flag_reg <= 1'b0;
         trg_flag_reg <= 1'b0;
      end else if (CLK_EN) begin
         upd_flag_reg <= upd_flag_next;
         trg_flag_reg <= trg_flag_next;
      end
   end

   // ==================================================
   // Channel flags

   logic [NCHAN-1:0] chan_evt_flag;
   logic [NCHAN-1:0] chan_ovc_flag;

   // One flag pair per channel, bits 1.. and 9..
   for (genvar i = 0; i < NCHAN; i++) begin : g_chan
      tsf_chan_flags u_chan (
         .clk        (SYS_CLK),
         .rst        (RESET),
         .ce         (CLK_EN),
         .input_mode (chan_input_mode[i]),
         .center     (center_aligned),
         .match      (CH_MATCH[i]),
         .capture    (CH_CAPTURE[i]),
         .cap_read   (CH_CAP_READ[i]),
         .clr_evt    (clr_bits[BIT_CH1 + i]),
         .clr_ovc    (clr_bits[BIT_OVC1 + i]),
         .evt_flag   (chan_evt_flag[i]),
         .ovc_flag   (chan_ovc_flag[i])
      );
   end

   // ==================================================
   // Status word

   logic [15:0] status_word;

   // Reserved positions are tied to zero
   always_comb begin
      status_word                         = STATUS_RST;
      status_word[BIT_UPD]                = upd_flag_reg;
      status_word[BIT_TRG]                = trg_flag_reg;
      status_word[BIT_CH1 +: NCHAN]       = chan_evt_flag;
      status_word[BIT_OVC1 +: NCHAN]      = chan_ovc_flag;
   end

   // ==================================================
   // Interrupt

   logic [15:0] irq_pending;
   logic        irq_next;

   // Each flag only reaches the line through its own enable
   assign irq_pending = status_word & mask_reg;
   assign irq_next    = |irq_pending;

   // ==================================================
   // Read data

   logic [15:0]       rd_word;
   logic [DATA_W-1:0] rdata_next;

   // Event generation and unmapped addresses read zero
   assign rd_word = rd_status ? status_word
                  : rd_mask   ? mask_reg
                  : rd_ctrl   ? ctrl_reg
                  : 16'h0000;
   // Data stand only in the cycle after the strobe
   assign rdata_next = REG_RD ? DATA_W'(rd_word) : '0;

   // ==================================================
   // Output registers

   // Pulses lag their cause by one cycle, like the flags
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         REG_RDATA      <= '0;
         UPDATE_EVT     <= 1'b0;
         COUNTER_REINIT <= 1'b0;
         TRIGGER_EVT    <= 1'b0;
         IRQ            <= 1'b0;
      end else if (CLK_EN) begin
         REG_RDATA      <= rdata_next;
         UPDATE_EVT     <= upd_evt;
         COUNTER_REINIT <= update_generate | trig_reinit;
         TRIGGER_EVT    <= trig_evt;
         IRQ            <= irq_next;
      end
   end

endmodule : tsf_flags

`default_nettype wire

// >>> verilog/tsf_pkg.sv
// Shared constants of the timer status flag block
`default_nettype none

package tsf_pkg;

   // ==================================================
   // Bus geometry
   localparam int TSF_ADDR_W = 8;
   localparam int TSF_DATA_W = 16;
   localparam int TSF_NCHAN  = 2;

   // ==================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_MASK   = 8'h04;
   localparam logic [7:0] OFS_CTRL   = 8'h08;
   localparam logic [7:0] OFS_EVGEN  = 8'h0C;

   // ==================================================
   // Status / mask field positions
   localparam int BIT_UPD  = 0;
   localparam int BIT_CH1  = 1;
   localparam int BIT_TRG  = 6;
   localparam int BIT_OVC1 = 9;
   localparam logic [15:0] FLAG_MASK  = 16'h0647;
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] MASK_RST   = 16'h0000;

   // ==================================================
   // Control register fields
   localparam int CTL_UPDATE_DISABLE   = 0;
   localparam int CTL_URS    = 1;
   localparam int CTL_SLV_LO = 2;
   localparam int CTL_POL    = 5;
   localparam int CTL_CH_IN  = 6;
   localparam int CTL_CENTER = 8;
   localparam logic [15:0] CTRL_MASK = 16'h01FF;
   localparam logic [15:0] CTRL_RST  = 16'h0000;

   // ==================================================
   // Event generation fields
   localparam int EVG_UG = 0;
   localparam int EVG_TG = 6;

   // Slave mode encodings
   typedef enum logic [2:0] {
      SLV_OFF     = 3'b000,
      SLV_RESET   = 3'b100,
      SLV_GATED   = 3'b101,
      SLV_TRIGGER = 3'b110,
      SLV_EXTCLK  = 3'b111
   } tsf_slave_e;

endpackage : tsf_pkg

`default_nettype wire

// >>> verilog/tsf_trig_edge.sv
// Trigger input edge detector for the timer status flag block
`default_nettype none
`timescale 1ns/1ps

module tsf_trig_edge
   import tsf_pkg::*;
(
   input  wire logic       clk,        // Kernel clock
   input  wire logic       rst,        // Async reset, high
   input  wire logic       ce,         // Clock enable
   input  wire logic       trig_in,    // Trigger input level
   input  wire logic [2:0] slave_mode, // Slave mode select
   input  wire logic       fall_sel,   // Valid edge is falling
   output logic            trig_evt    // Trigger edge seen
);

   logic prev_reg;
   logic rise;
   logic fall;
   logic gated;

   // Edge terms against the previous sample
   assign rise  = trig_in & ~prev_reg;
   assign fall  = ~trig_in & prev_reg;
   assign gated = (slave_mode == SLV_GATED);
   // Gated mode counts both edges, others only the valid one
   assign trig_evt = gated ? (rise | fall) : (fall_sel ? fall : rise);

   // Previous sample, frozen with the clock enable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_reg <= 1'b0;
      end else if (ce) begin
         prev_reg <= trig_in;
      end
   end

endmodule : tsf_trig_edge

`default_nettype wire

// >>> verilog/tsf_chan_flags.sv
// Event and over-capture flags of one compare/capture channel
`default_nettype none
`timescale 1ns/1ps

module tsf_chan_flags (
   input  wire logic clk,        // Kernel clock
   input  wire logic rst,        // Async reset, high
   input  wire logic ce,         // Clock enable
   input  wire logic input_mode, // Channel is capture input
   input  wire logic center,     // Centre-aligned counting
   input  wire logic match,      // Counter equals compare value
   input  wire logic capture,    // Capture copied into register
   input  wire logic cap_read,   // Capture register read
   input  wire logic clr_evt,    // Software clear of event flag
   input  wire logic clr_ovc,    // Software clear of over-capture
   output logic      evt_flag,   // Channel event flag
   output logic      ovc_flag    // Over-capture flag
);

   logic set_evt;
   logic kill_evt;
   logic set_ovc;
   logic evt_next;
   logic ovc_next;

   // Set sources by direction
   assign set_evt = input_mode ? capture : (match & ~center);
   // Capture register read clears only in input mode
   assign kill_evt = clr_evt | (input_mode & cap_read);
   // New capture on a still-pending event is an over-capture
   assign set_ovc = input_mode & capture & evt_flag;
   // Set beats a clear landing in the same cycle
   assign evt_next = set_evt | (evt_flag & ~kill_evt);
   assign ovc_next = set_ovc | (ovc_flag & ~clr_ovc);

   // Flag storage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         evt_flag <= 1'b0;
         ovc_flag <= 1'b0;
      end else if (ce) begin
         evt_flag <= evt_next;
         ovc_flag <= ovc_next;
      end
   end

endmodule : tsf_chan_flags

`default_nettype wire

// >>> tb/tsf_flags_checker.sv
// Port-level assertions for the timer status flag block
`timescale 1ns/1ps
`default_nettype none
module tsf_flags_checker
   import tsf_pkg::*;
(
   input wire logic        SYS_CLK,        // Clock
   input wire logic        RESET,          // Reset
   input wire logic        CLK_EN,         // Enable
   input wire logic [7:0]  REG_ADDR,       // Address
   input wire logic [15:0] REG_WDATA,      // Write data
   input wire logic        REG_WR,         // Write
   input wire logic        REG_RD,         // Read
   input wire logic [15:0] REG_RDATA,      // Read data
   input wire logic        REP_OVF_UNF,    // Wrap
   input wire logic        SW_REINIT,      // Reinit
   input wire logic        TRIGGER_INPUT,  // Trigger
   input wire logic [1:0]  CH_MATCH,       // Match
   input wire logic [1:0]  CH_CAPTURE,     // Capture
   input wire logic [1:0]  CH_CAP_READ,    // Capture read
   input wire logic        UPDATE_EVT,     // Update
   input wire logic        COUNTER_REINIT, // Reinit out
   input wire logic        TRIGGER_EVT,    // Trigger out
   input wire logic        IRQ             // Interrupt
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   // ==================================================
   // Bus requests seen by the block
   sequence stat_rd_s; CLK_EN && REG_RD && REG_ADDR == OFS_STATUS; endsequence
   sequence evg_rd_s; CLK_EN && REG_RD && REG_ADDR == OFS_EVGEN; endsequence
   sequence tg_wr_s; CLK_EN && REG_WR && REG_ADDR == OFS_EVGEN && REG_WDATA[EVG_TG]; endsequence
   sequence ug_wr_s; CLK_EN && REG_WR && REG_ADDR == OFS_EVGEN && REG_WDATA[EVG_UG]; endsequence

   // Read data; enable guard since a frozen clock holds the data
   rd_idle_zero_a:
   assert property (!$past(REG_RD) && $past(CLK_EN) |-> REG_RDATA == 16'h0000)
      else $error("read data not zero outside read slot");
   rsvd_zero_a:
   assert property (stat_rd_s |=> (REG_RDATA & ~FLAG_MASK) == 16'h0000)
      else $error("reserved status bits read non-zero");
   evgen_zero_a:
   assert property (evg_rd_s |=> REG_RDATA == 16'h0000)
      else $error("event generate register read non-zero");

   // Generate bits make their events one cycle later
   tg_trig_pulse_a:
   assert property (tg_wr_s |=> TRIGGER_EVT)
      else $error("trigger generate gave no trigger event");
   ug_reinit_a:
   assert property (ug_wr_s |=> COUNTER_REINIT)
      else $error("update generate gave no reinit");

   // Every pulse needs a cause; two enabled edges keep the history exact
   trig_cause_a:
   assert property (TRIGGER_EVT && $past(CLK_EN) && $past(CLK_EN, 2) |->
      $past(TRIGGER_INPUT) != $past(TRIGGER_INPUT, 2) ||
      $past(REG_WR && REG_ADDR == OFS_EVGEN && REG_WDATA[EVG_TG]))
      else $error("trigger event without edge or generate");
   upd_cause_a:
   assert property (UPDATE_EVT && $past(CLK_EN) |->
      $past(REP_OVF_UNF || SW_REINIT) || COUNTER_REINIT)
      else $error("update event without source");
   reinit_cause_a:
   assert property (COUNTER_REINIT && $past(CLK_EN) |->
      $past(REG_WR && REG_ADDR == OFS_EVGEN && REG_WDATA[EVG_UG]) || TRIGGER_EVT)
      else $error("reinit without generate or trigger");
   irq_cause_a:
   assert property ($rose(IRQ) && $past(CLK_EN) && $past(CLK_EN, 2) |->
      $past(UPDATE_EVT || TRIGGER_EVT) ||
      $past((|CH_MATCH) || (|CH_CAPTURE) || (REG_WR && REG_ADDR == OFS_MASK), 2))
      else $error("interrupt rose without flag or mask cause");
endmodule : tsf_flags_checker
`default_nettype wire

// >>> tb/test_timer_status_flags.sv
// Self-checking bench for the timer status flag block
`timescale 1ns/1ps
`default_nettype none
module test_timer_status_flags import tsf_pkg::*;;
   logic        sys_clk = 1'h0;
   logic        reset = 1'h1;
   logic        clk_en = 1'h1;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'h0;
   logic        reg_rd = 1'h0;
   logic        rep_ovf = 1'h0;
   logic        sw_reinit = 1'h0;
   logic        trig_in = 1'h0;
   logic [1:0]  ch_match = 2'h0;
   logic [1:0]  ch_capture = 2'h0;
   logic [1:0]  ch_cap_read = 2'h0;
   logic [15:0] reg_rdata;
   logic        update_evt;
   logic        counter_reinit;
   logic        trigger_evt;
   logic        irq;
   int          mismatches = 0;
   int          tests_run = 0;

   // ==================================================
   // Clock and device
   always #4 sys_clk = ~sys_clk;

   tsf_flags dut (.SYS_CLK(sys_clk), .RESET(reset), .CLK_EN(clk_en), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .REP_OVF_UNF(rep_ovf), .SW_REINIT(sw_reinit), .TRIGGER_INPUT(trig_in),
      .CH_MATCH(ch_match), .CH_CAPTURE(ch_capture), .CH_CAP_READ(ch_cap_read),
      .UPDATE_EVT(update_evt), .COUNTER_REINIT(counter_reinit),
      .TRIGGER_EVT(trigger_evt), .IRQ(irq));

   // ==================================================
   // Shared drivers and compare
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'h1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask : wr

   // Data are looked at only in the single cycle they stand
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_rd   <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, exp);
   endtask : rd

   task automatic st(input logic [15:0] exp);
      rd(OFS_STATUS, exp);
   endtask : st

   task automatic clr;
      wr(OFS_STATUS, 16'h0000);
   endtask : clr

   // Packed as read, capture, match (two bits each), reinit, wrap
   task automatic pulse(input logic [7:0] v);
      @(posedge sys_clk);
      {ch_cap_read, ch_capture, ch_match, sw_reinit, rep_ovf} <= v;
      @(posedge sys_clk);
      {ch_cap_read, ch_capture, ch_match, sw_reinit, rep_ovf} <= 8'h00;
   endtask : pulse

   task automatic trig(input logic v);
      @(posedge sys_clk);
      trig_in <= v;
      @(posedge sys_clk);
   endtask : trig

   task automatic irq_is(input logic v);
      @(posedge sys_clk);
      #1 chk({15'h0000, irq}, {15'h0000, v});
   endtask : irq_is

   // Event pulses {update, reinit, trigger} in the cycle after the cause
   task automatic ev(input logic [2:0] v);
      #1 chk({13'h0000, update_evt, counter_reinit, trigger_evt}, {13'h0000, v});
   endtask : ev

   // ==================================================
   // Scenarios
   task automatic t_regs;
      st(16'h0000);
      wr(OFS_STATUS, 16'hFFFF);
      st(16'h0000);
      wr(OFS_MASK, 16'hFFFF);
      rd(OFS_MASK, 16'h0647);
      wr(8'h10, 16'h1234);
      rd(8'h10, 16'h0000);
      rd(OFS_EVGEN, 16'h0000);
      wr(OFS_MASK, 16'h0000);
   endtask : t_regs

   task automatic t_update;
      pulse(8'h01);
      ev(3'h4);
      st(16'h0001);
      st(16'h0001);
      clr;
      wr(OFS_CTRL, 16'h0001);
      pulse(8'h01);
      ev(3'h0);
      wr(OFS_EVGEN, 16'h0001);
      ev(3'h2);
      st(16'h0000);
      wr(OFS_CTRL, 16'h0002);
      pulse(8'h02);
      ev(3'h4);
      wr(OFS_EVGEN, 16'h0001);
      st(16'h0000);
      pulse(8'h01);
      st(16'h0001);
      clr;
      wr(OFS_CTRL, 16'h0000);
      pulse(8'h02);
      st(16'h0001);
      clr;
      wr(OFS_EVGEN, 16'h0001);
      st(16'h0001);
      clr;
      wr(OFS_CTRL, 16'h0010);
      trig(1'h1);
      ev(3'h7);
      st(16'h0041);
      clr;
      wr(OFS_CTRL, 16'h0012);
      trig(1'h0);
      trig(1'h1);
      st(16'h0040);
      trig(1'h0);
      clr;
      wr(OFS_CTRL, 16'h0000);
   endtask : t_update

   task automatic t_trigger;
      trig(1'h1);
      st(16'h0040);
      clr;
      trig(1'h0);
      st(16'h0000);
      wr(OFS_CTRL, 16'h0020);
      trig(1'h1);
      st(16'h0000);
      trig(1'h0);
      st(16'h0040);
      clr;
      wr(OFS_CTRL, 16'h0014);
      trig(1'h1);
      st(16'h0040);
      clr;
      trig(1'h0);
      st(16'h0040);
      wr(OFS_CTRL, 16'h0000);
      clr;
      wr(OFS_EVGEN, 16'h0040);
      ev(3'h1);
      st(16'h0040);
      clr;
   endtask : t_trigger

   // Output mode first, then both channels as capture inputs
   task automatic t_chan;
      pulse(8'h04);
      st(16'h0002);
      pulse(8'h08);
      st(16'h0006);
      clr;
      pulse(8'h30);
      st(16'h0000);
      wr(OFS_CTRL, 16'h0100);
      pulse(8'h04);
      st(16'h0000);
      wr(OFS_CTRL, 16'h00C0);
      pulse(8'h0C);
      st(16'h0000);
      pulse(8'h10);
      st(16'h0002);
      wr(OFS_STATUS, 16'hFFFD);
      st(16'h0000);
      pulse(8'h10);
      pulse(8'h10);
      st(16'h0202);
      pulse(8'h40);
      st(16'h0200);
      wr(OFS_STATUS, 16'hFDFF);
      pulse(8'h10);
      st(16'h0002);
      clr;
      pulse(8'h20);
      pulse(8'h20);
      st(16'h0404);
      pulse(8'h80);
      st(16'h0400);
      clr;
      wr(OFS_CTRL, 16'h0000);
   endtask : t_chan

   // Raise, mask, unmask and clear; then a frozen clock ignores events
   task automatic t_irq;
      wr(OFS_MASK, 16'h0040);
      wr(OFS_EVGEN, 16'h0040);
      #1 chk({15'h0000, irq}, 16'h0000);
      irq_is(1'h1);
      wr(OFS_MASK, 16'h0000);
      irq_is(1'h0);
      wr(OFS_MASK, 16'h0040);
      irq_is(1'h1);
      wr(OFS_STATUS, 16'hFFBF);
      irq_is(1'h0);
      @(posedge sys_clk);
      clk_en <= 1'h0;
      pulse(8'h01);
      wr(OFS_EVGEN, 16'h0040);
      ev(3'h0);
      @(posedge sys_clk);
      clk_en <= 1'h1;
      st(16'h0000);
   endtask : t_irq

   // ==================================================
   // Run control
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   // Guard against a hung sequence
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      wrap_up;
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      reset <= 1'h0;
      t_regs;
      t_update;
      t_trigger;
      t_chan;
      t_irq;
      wrap_up;
   end
endmodule : test_timer_status_flags

bind tsf_flags tsf_flags_checker chk_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .CLK_EN(CLK_EN),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .REP_OVF_UNF(REP_OVF_UNF), .SW_REINIT(SW_REINIT),
   .TRIGGER_INPUT(TRIGGER_INPUT), .CH_MATCH(CH_MATCH), .CH_CAPTURE(CH_CAPTURE),
   .CH_CAP_READ(CH_CAP_READ), .UPDATE_EVT(UPDATE_EVT), .COUNTER_REINIT(COUNTER_REINIT),
   .TRIGGER_EVT(TRIGGER_EVT), .IRQ(IRQ));
`default_nettype wire
